// ---- logic/ufw_uart.sv ----
/*
 Serial transmitter and receiver with eight-entry queues, a baud ratio and watermark
 events, reached as an AHB-Lite slave. Assumes one clock, hclk at 40 MHz, and a
 remote partner that keeps to the character format.
*/
// Implementation choice: the AHB-Lite slave port.
`include "ufw_defines.svh"
module ufw_uart #(
   parameter int DEPTH = 8,
   parameter int DIV_WIDTH = 20,
   parameter logic [19:0] DIV_INIT = 20'(`UFW_DIV_INIT)
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire ufw_pkg::ufw_ahb_req_type ahb_req,
   input wire logic [31:0] hwdata,
   output ufw_pkg::ufw_ahb_rsp_type ahb_rsp,
   input wire logic rxd,
   output logic txd,
   output logic event_irq
);
   import ufw_pkg::*;
   localparam int AW = $clog2(DEPTH);
   ////////////////////////////////////////////////////////////////////////////////
   logic wr_pend;
   logic rd_pend;
   logic [7:0] addr_q;
   ufw_chan_cfg_type send_cfg;
   ufw_chan_cfg_type recv_cfg;
   logic [1:0] irq_enable;
   logic [DIV_WIDTH-1:0] baud_ratio;
   logic [7:0] txq [DEPTH];
   logic [7:0] rxq [DEPTH];
   logic [AW:0] tx_wp, tx_rp, rx_wp, rx_rp;
   logic [AW:0] tx_count, rx_count;
   logic tx_full, rx_empty;
   logic tx_push, tx_pop, rx_push, rx_pop;
   logic [7:0] rx_byte;
   logic [1:0] pending;
   logic addr_ok;
   assign tx_count = tx_wp - tx_rp;
   assign rx_count = rx_wp - rx_rp;
   assign tx_full = tx_count == (AW+1)'(DEPTH);
   assign rx_empty = rx_count == '0;
   assign addr_ok = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
   // Pending bits follow the counts combinationally; there is nothing to clear.
   assign pending[`UFW_BIT_IRQ_SEND] = tx_count < {1'b0, send_cfg.level};
   assign pending[`UFW_BIT_IRQ_RECV] = rx_count > {1'b0, recv_cfg.level};
   ////////////////////////////////////////////////////////////////////////////////
   // Writes answer with no wait state; every read answers after one wait state.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         addr_q <= 8'h00;
      end
      else
      begin
         wr_pend <= addr_ok && ahb_req.hwrite;
         rd_pend <= addr_ok && !ahb_req.hwrite;
         if (addr_ok)
            addr_q <= ahb_req.haddr[7:0];
      end
   end
   // Read data are captured in the read's data phase, after a write still in its own data
   // phase has landed, so a read straight after a write never returns stale state.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ahb_rsp <= '{hrdata: 32'h0000_0000, hreadyout: 1'b1, hresp: 1'b0};
      else
      begin
         ahb_rsp.hreadyout <= !(addr_ok && !ahb_req.hwrite);
         ahb_rsp.hresp <= 1'b0;
         ahb_rsp.hrdata <= 32'h0000_0000;
         if (rd_pend)
            unique case (addr_q)
               `UFW_OFS_SEND_PORT: ahb_rsp.hrdata[`UFW_BIT_FLAG] <= tx_full;
               `UFW_OFS_RECEIVE_PORT:
               begin
                  ahb_rsp.hrdata[`UFW_BIT_FLAG] <= rx_empty;
                  ahb_rsp.hrdata[7:0] <= rxq[rx_rp[AW-1:0]];
               end
               `UFW_OFS_SEND_CONFIG:
               begin
                  ahb_rsp.hrdata[`UFW_BIT_ENABLE] <= send_cfg.enable;
                  ahb_rsp.hrdata[`UFW_BIT_NSTOP] <= send_cfg.two_stop;
                  ahb_rsp.hrdata[`UFW_MSB_LEVEL:`UFW_LSB_LEVEL] <= send_cfg.level;
               end
               `UFW_OFS_RECEIVE_CONFIG:
               begin
                  ahb_rsp.hrdata[`UFW_BIT_ENABLE] <= recv_cfg.enable;
                  ahb_rsp.hrdata[`UFW_MSB_LEVEL:`UFW_LSB_LEVEL] <= recv_cfg.level;
               end
               `UFW_OFS_IRQ_ENABLE: ahb_rsp.hrdata[1:0] <= irq_enable;
               `UFW_OFS_IRQ_PENDING: ahb_rsp.hrdata[1:0] <= pending;
               `UFW_OFS_BAUD_RATIO: ahb_rsp.hrdata[DIV_WIDTH-1:0] <= baud_ratio;
               default: ahb_rsp.hrdata <= 32'h0000_0000;
            endcase
      end
   end
   // A receive read pops at the edge that captures its data.
   assign rx_pop = rd_pend && addr_q == `UFW_OFS_RECEIVE_PORT && !rx_empty;
   assign tx_push = wr_pend && addr_q == `UFW_OFS_SEND_PORT && !tx_full;
   ////////////////////////////////////////////////////////////////////////////////
   // Writes to the receive port and the pending register fall through unused.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         send_cfg <= '0;
         recv_cfg <= '0;
         irq_enable <= `UFW_RST_IRQ_ENABLE;
         baud_ratio <= DIV_WIDTH'(DIV_INIT);
      end
      else if (wr_pend)
      begin
         unique case (addr_q)
            `UFW_OFS_SEND_CONFIG:
            begin
               send_cfg.enable <= hwdata[`UFW_BIT_ENABLE];
               send_cfg.two_stop <= hwdata[`UFW_BIT_NSTOP];
               send_cfg.level <= hwdata[`UFW_MSB_LEVEL:`UFW_LSB_LEVEL];
            end
            `UFW_OFS_RECEIVE_CONFIG:
            begin
               recv_cfg.enable <= hwdata[`UFW_BIT_ENABLE];
               recv_cfg.level <= hwdata[`UFW_MSB_LEVEL:`UFW_LSB_LEVEL];
            end
            `UFW_OFS_IRQ_ENABLE: irq_enable <= hwdata[1:0];
            `UFW_OFS_BAUD_RATIO: baud_ratio <= hwdata[DIV_WIDTH-1:0];
            default: irq_enable <= irq_enable;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Queue storage; pointers carry one extra bit so full and empty are distinct.
   always_ff @(posedge hclk)
   begin
      if (tx_push)
         txq[tx_wp[AW-1:0]] <= hwdata[7:0];
      if (rx_push)
         rxq[rx_wp[AW-1:0]] <= rx_byte;
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tx_wp <= '0;
         tx_rp <= '0;
         rx_wp <= '0;
         rx_rp <= '0;
      end
      else
      begin
         tx_wp <= tx_wp + (AW+1)'(tx_push);
         tx_rp <= tx_rp + (AW+1)'(tx_pop);
         rx_wp <= rx_wp + (AW+1)'(rx_push);
         rx_rp <= rx_rp + (AW+1)'(rx_pop);
      end
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         event_irq <= 1'b0;
      else
         event_irq <= |(pending & irq_enable);
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Transmit bit timer: one bit lasts baud_ratio+1 clocks.
   ufw_tx_state_type tx_state;
   logic [DIV_WIDTH-1:0] tx_tick;
   logic [7:0] tx_shift;
   logic [2:0] tx_bit;
   logic tx_bit_end;
   assign tx_bit_end = tx_tick == '0;
   assign tx_pop = tx_state == UFW_TX_IDLE && send_cfg.enable && tx_count != '0;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tx_state <= UFW_TX_IDLE;
         tx_tick <= '0;
         tx_shift <= 8'h00;
         tx_bit <= 3'h0;
         txd <= 1'b1;
      end
      else
      begin
         tx_tick <= tx_bit_end ? baud_ratio : tx_tick - DIV_WIDTH'(1);
         unique case (tx_state)
            UFW_TX_IDLE:
            begin
               txd <= 1'b1;
               if (tx_pop)
               begin
                  tx_shift <= txq[tx_rp[AW-1:0]];
                  tx_tick <= baud_ratio;
                  txd <= 1'b0;
                  tx_state <= UFW_TX_START;
               end
            end
            UFW_TX_START:
               if (tx_bit_end)
               begin
                  txd <= tx_shift[0];
                  tx_shift <= tx_shift >> 1;
                  tx_bit <= 3'h0;
                  tx_state <= UFW_TX_DATA;
               end
            UFW_TX_DATA:
               if (tx_bit_end)
               begin
                  if (tx_bit == 3'h7)
                  begin
                     txd <= 1'b1;
                     tx_bit <= {2'h0, send_cfg.two_stop};
                     tx_state <= UFW_TX_STOP;
                  end
                  else
                  begin
                     txd <= tx_shift[0];
                     tx_shift <= tx_shift >> 1;
                     tx_bit <= tx_bit + 3'h1;
                  end
               end
            UFW_TX_STOP:
               if (tx_bit_end)
               begin
                  if (tx_bit == 3'h0)
                     tx_state <= UFW_TX_IDLE;
                  else
                     tx_bit <= 3'h0;
               end
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Three-stage input synchroniser; a change counts when stages two and three agree.
   logic [2:0] rx_sync;
   logic rx_line;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rx_sync <= 3'h7;
         rx_line <= 1'b1;
      end
      else
      begin
         rx_sync <= {rx_sync[1:0], rxd};
         if (rx_sync[1] == rx_sync[2])
            rx_line <= rx_sync[2];
      end
   end
   // Sixteen oversample ticks are spread over every baud_ratio+1 clocks by a fractional
   // accumulator, so both directions keep one bit rate; ratios below fifteen break this.
   logic [DIV_WIDTH:0] os_acc;
   logic [DIV_WIDTH:0] os_sum;
   logic os_tick;
   assign os_sum = os_acc + (DIV_WIDTH+1)'(`UFW_OVERSAMPLE);
   assign os_tick = os_sum > {1'b0, baud_ratio};
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         os_acc <= '0;
      else if (os_tick)
         os_acc <= os_sum - {1'b0, baud_ratio} - (DIV_WIDTH+1)'(1);
      else
         os_acc <= os_sum;
   end
   ufw_rx_state_type rx_state;
   logic [3:0] rx_phase;
   logic [2:0] rx_votes;
   logic [2:0] rx_bit;
   logic rx_value;
   assign rx_value = (rx_votes[0] & rx_votes[1]) | (rx_votes[1] & rx_votes[2])
      | (rx_votes[0] & rx_votes[2]);
   assign rx_push = rx_state == UFW_RX_STOP && os_tick && rx_phase == 4'hf
      && rx_value && recv_cfg.enable && !rx_full_guard();
   function automatic logic rx_full_guard();
      return rx_count == (AW+1)'(DEPTH);
   endfunction : rx_full_guard
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rx_state <= UFW_RX_IDLE;
         rx_phase <= 4'h0;
         rx_votes <= 3'h7;
         rx_bit <= 3'h0;
         rx_byte <= 8'h00;
      end
      else if (!recv_cfg.enable)
         rx_state <= UFW_RX_IDLE;
      else if (os_tick)
      begin
         rx_phase <= rx_phase + 4'h1;
         if (rx_phase >= 4'(`UFW_VOTE_FIRST) && rx_phase <= 4'(`UFW_VOTE_FIRST + 2))
            rx_votes <= {rx_votes[1:0], rx_line};
         unique case (rx_state)
            UFW_RX_IDLE:
               if (!rx_line)
               begin
                  rx_phase <= 4'h1;
                  rx_state <= UFW_RX_START;
               end
            UFW_RX_START:
               if (rx_phase == 4'hf)
               begin
                  rx_bit <= 3'h0;
                  rx_state <= rx_value ? UFW_RX_IDLE : UFW_RX_DATA;
               end
            UFW_RX_DATA:
               if (rx_phase == 4'hf)
               begin
                  rx_byte <= {rx_value, rx_byte[7:1]};
                  rx_bit <= rx_bit + 3'h1;
                  if (rx_bit == 3'h7)
                     rx_state <= UFW_RX_STOP;
               end
            UFW_RX_STOP:
               if (rx_phase == 4'hf)
                  rx_state <= UFW_RX_IDLE;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   property p_tx_full_drop;
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend && addr_q == `UFW_OFS_SEND_PORT && tx_full) |=> $stable(tx_wp);
   endproperty
   a_tx_full_drop: assert property (p_tx_full_drop) else $error("write into full queue");
   property p_tx_idle_high;
      @(posedge hclk) disable iff (!hresetn)
      (!send_cfg.enable && tx_state == UFW_TX_IDLE) [*2] |-> txd;
   endproperty
   a_tx_idle_high: assert property (p_tx_idle_high) else $error("line low while off");
   property p_rx_off;
      @(posedge hclk) disable iff (!hresetn)
      !recv_cfg.enable |=> !rx_push;
   endproperty
   a_rx_off: assert property (p_rx_off) else $error("push while disabled");
   property p_rx_pop;
      @(posedge hclk) disable iff (!hresetn)
      rx_pop |=> rx_rp == $past(rx_rp) + (AW+1)'(1);
   endproperty
   a_rx_pop: assert property (p_rx_pop) else $error("read did not pop");
   property p_empty_flag;
      @(posedge hclk) disable iff (!hresetn)
      (rd_pend && addr_q == `UFW_OFS_RECEIVE_PORT && rx_empty) |=> ahb_rsp.hrdata[31];
   endproperty
   a_empty_flag: assert property (p_empty_flag) else $error("empty not flagged");
   property p_event;
      @(posedge hclk) disable iff (!hresetn)
      ##1 event_irq == $past(|(pending & irq_enable));
   endproperty
   a_event: assert property (p_event) else $error("event mismatch");
   property p_count_bound;
      @(posedge hclk) disable iff (!hresetn)
      tx_count <= (AW+1)'(DEPTH) && rx_count <= (AW+1)'(DEPTH);
   endproperty
   a_count_bound: assert property (p_count_bound) else $error("queue overflow");
   property p_start_low;
      @(posedge hclk) disable iff (!hresetn)
      tx_pop |=> !txd && tx_state == UFW_TX_START;
   endproperty
   a_start_low: assert property (p_start_low) else $error("no start bit");
   c_tx_char: cover property (@(posedge hclk) tx_state == UFW_TX_STOP ##1 tx_state == UFW_TX_IDLE);
   c_rx_char: cover property (@(posedge hclk) rx_push);
   c_tx_full: cover property (@(posedge hclk) tx_full);
endmodule : ufw_uart

// ---- pkg/ufw_defines.svh ----
/*
 Offsets, field positions, reset values and timing counts of the serial port block.
 Assumes it is included by bare name wherever these constants are needed.
*/
`ifndef UFW_DEFINES_SVH
`define UFW_DEFINES_SVH
`define UFW_OFS_SEND_PORT 8'h00
`define UFW_OFS_RECEIVE_PORT 8'h04
`define UFW_OFS_SEND_CONFIG 8'h08
`define UFW_OFS_RECEIVE_CONFIG 8'h0c
`define UFW_OFS_IRQ_ENABLE 8'h10
`define UFW_OFS_IRQ_PENDING 8'h14
`define UFW_OFS_BAUD_RATIO 8'h18
`define UFW_BIT_FLAG 31
`define UFW_BIT_ENABLE 0
`define UFW_BIT_NSTOP 1
`define UFW_LSB_LEVEL 16
`define UFW_MSB_LEVEL 18
`define UFW_BIT_IRQ_SEND 0
`define UFW_BIT_IRQ_RECV 1
`define UFW_RST_CONFIG 32'h0000_0000
`define UFW_RST_IRQ_ENABLE 2'h0
`define UFW_DIV_INIT 289
`define UFW_OVERSAMPLE 16
`define UFW_VOTE_FIRST 7
`endif

// ---- pkg/ufw_pkg.sv ----
/*
 Types shared by the serial port block.
 Assumes the constants header is compiled alongside.
*/
package ufw_pkg;
   typedef struct packed
   {
      logic [1:0] htrans;
      logic [31:0] haddr;
      logic hwrite;
      logic [2:0] hsize;
      logic hsel;
      logic hready;
   } ufw_ahb_req_type;
   typedef struct packed
   {
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } ufw_ahb_rsp_type;
   typedef struct packed
   {
      logic enable;
      logic two_stop;
      logic [2:0] level;
   } ufw_chan_cfg_type;
   typedef enum logic [1:0] {UFW_TX_IDLE, UFW_TX_START, UFW_TX_DATA, UFW_TX_STOP}
      ufw_tx_state_type;
   typedef enum logic [1:0] {UFW_RX_IDLE, UFW_RX_START, UFW_RX_DATA, UFW_RX_STOP}
      ufw_rx_state_type;
endpackage : ufw_pkg

// ---- tb/ufw_remote.sv ----
/*
 Behavioural remote serial transceiver on the far side of the two pins.
 Assumes it shares the bench clock and a bit length of BIT_CLKS clocks.
*/
module ufw_remote #(
   parameter int BIT_CLKS = 32
) (
   input wire logic hclk,
   input wire logic txd,
   output logic rxd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got_q[$];
   int start_q[$];
   int stop_bad = 0;
   int now_clk = 0;
   initial rxd = 1'b1;
   always @(posedge hclk) now_clk <= now_clk + 1;
   ////////////////////////////////////////////////////////////////////////////////
   // Start times let the bench measure the spacing that the stop count gives.
   always
   begin : catch_char
      logic [7:0] d;
      @(negedge txd);
      start_q.push_back(now_clk);
      repeat (BIT_CLKS / 2) @(posedge hclk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT_CLKS) @(posedge hclk);
         d[i] = txd;
      end
      repeat (BIT_CLKS) @(posedge hclk);
      if (txd !== 1'b1) stop_bad++;
      got_q.push_back(d);
   end
   ////////////////////////////////////////////////////////////////////////////////
   // A broken stop bit is low for only three quarters of a bit, so the tail cannot pass
   // for a real start bit once the receiver has dropped the character.
   task automatic send_char(input logic [7:0] d, input logic bad_stop);
      rxd <= 1'b0;
      repeat (BIT_CLKS) @(posedge hclk);
      for (int i = 0; i < 8; i++)
      begin
         rxd <= d[i];
         repeat (BIT_CLKS) @(posedge hclk);
      end
      rxd <= ~bad_stop;
      repeat (BIT_CLKS * 3 / 4) @(posedge hclk);
      rxd <= 1'b1;
      repeat (BIT_CLKS * 9 / 4) @(posedge hclk);
   endtask : send_char
   task automatic glitch(input int n);
      rxd <= 1'b0;
      repeat (n) @(posedge hclk);
      rxd <= 1'b1;
      repeat (BIT_CLKS * 2) @(posedge hclk);
   endtask : glitch
endmodule : ufw_remote

// ---- tb/ufw_uart_bench.sv ----
/*
 Self-checking bench for the serial port block: bus master tasks, queues, watermarks, link.
 Assumes the design, its package and the remote model are compiled first.
*/
`include "ufw_defines.svh"
module ufw_uart_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import ufw_pkg::*;
   localparam int BIT_CLKS = 32;
   localparam int LIMIT = 40000;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic [1:0] tr = 2'b00;
   logic [7:0] addr = 8'h00;
   logic wr = 1'b0;
   logic sel = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   ufw_ahb_req_type ahb_req;
   ufw_ahb_rsp_type ahb_rsp;
   logic rxd;
   logic txd;
   logic event_irq;
   logic [31:0] rd;
   logic [7:0] exp_q[$];
   int bad_count = 0;
   int n_checks = 0;
   int cycles = 0;
   assign ahb_req = {tr, 24'h00_0000, addr, wr, 3'b010, sel, ahb_rsp.hreadyout};
   always #12.5 hclk = ~hclk;
   ufw_uart ufw_uart_inst (.hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req),
      .hwdata(hwdata), .ahb_rsp(ahb_rsp), .rxd(rxd), .txd(txd), .event_irq(event_irq));
   ufw_remote #(.BIT_CLKS(BIT_CLKS)) ufw_remote_inst (.hclk(hclk), .txd(txd), .rxd(rxd));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] exp_pending(int tx_n, int tx_lvl, int rx_n, int rx_lvl);
      return {30'h0, rx_n > rx_lvl, tx_n < tx_lvl};
   endfunction : exp_pending
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Called just after a rising edge; each phase is held until hready is seen high there.
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
      tr <= 2'b10;
      addr <= a;
      wr <= w;
      sel <= 1'b1;
      do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
      tr <= 2'b00;
      sel <= 1'b0;
      hwdata <= wd;
      do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
      rd = ahb_rsp.hrdata;
   endtask : bus
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0000_0000);
      check(what, rd, exp);
      check("hresp", {31'h0, ahb_rsp.hresp}, 32'h0);
   endtask : rd_chk
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report
   always @(posedge hclk)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         bad_count++;
         $display("[FAIL] run time expected below %0d seen %0d", LIMIT, cycles);
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [31:0] w;
      int n;
      void'($urandom(32'h74d0));
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk("send_config", `UFW_OFS_SEND_CONFIG, `UFW_RST_CONFIG);
      rd_chk("receive_config", `UFW_OFS_RECEIVE_CONFIG, `UFW_RST_CONFIG);
      rd_chk("irq_enable", `UFW_OFS_IRQ_ENABLE, 32'(`UFW_RST_IRQ_ENABLE));
      rd_chk("baud_ratio", `UFW_OFS_BAUD_RATIO, 32'(`UFW_DIV_INIT));
      rd_chk("irq_pending", `UFW_OFS_IRQ_PENDING, exp_pending(0, 0, 0, 0));
      rd_chk("unmapped", 8'h1c, 32'h0000_0000);
      check("txd idle", {31'h0, txd}, 32'h1);
      $display("test reset done");
      wr_reg(`UFW_OFS_BAUD_RATIO, 32'(BIT_CLKS - 1));
      wr_reg(`UFW_OFS_IRQ_ENABLE, 32'h1);
      rd_chk("irq_enable rw", `UFW_OFS_IRQ_ENABLE, 32'h1);
      for (int m = 0; m < 2; m++)
      begin
         wr_reg(`UFW_OFS_SEND_CONFIG, 32'h0003_0000);
         exp_q.delete();
         ufw_remote_inst.got_q.delete();
         ufw_remote_inst.start_q.delete();
         for (int i = 0; i < 9; i++)
         begin
            w = $urandom;
            if (i < 8) exp_q.push_back(w[7:0]);
            wr_reg(`UFW_OFS_SEND_PORT, w);
            bus(`UFW_OFS_IRQ_PENDING, 1'b0, 32'h0);
            check("send mark", rd, exp_pending((i < 8) ? i + 1 : 8, 3, 0, 0));
            check("event out", {31'h0, event_irq}, {31'h0, i < 2});
         end
         rd_chk("send full", `UFW_OFS_SEND_PORT, 32'h8000_0000);
         check("txd held", {31'h0, txd}, 32'h1);
         wr_reg(`UFW_OFS_SEND_CONFIG, {30'h0, m[0], 1'b1});
         n = 0;
         while (ufw_remote_inst.got_q.size() < 8 && n < 12 * 8 * BIT_CLKS)
         begin
            @(posedge hclk);
            n++;
         end
         repeat (12 * BIT_CLKS) @(posedge hclk);
         check("chars sent", 32'(ufw_remote_inst.got_q.size()), 32'd8);
         for (int i = 0; i < ufw_remote_inst.got_q.size() && i < 8; i++)
            check("sent char", 32'(ufw_remote_inst.got_q[i]), 32'(exp_q[i]));
         for (int i = 1; i < ufw_remote_inst.start_q.size(); i++)
         begin
            n = ufw_remote_inst.start_q[i] - ufw_remote_inst.start_q[i - 1];
            n = n - (10 + m) * BIT_CLKS;
            check("char spacing", {31'h0, n >= 0 && n <= 2}, 32'h1);
         end
         check("stop bits", 32'(ufw_remote_inst.stop_bad), 32'h0);
         rd_chk("send room", `UFW_OFS_SEND_PORT, 32'h0000_0000);
         $display("test send mode %0d done", m);
      end
      wr_reg(`UFW_OFS_IRQ_ENABLE, 32'h2);
      ufw_remote_inst.send_char(8'h5a, 1'b0);
      bus(`UFW_OFS_RECEIVE_PORT, 1'b0, 32'h0);
      check("receive off", {31'h0, rd[31]}, 32'h1);
      wr_reg(`UFW_OFS_RECEIVE_PORT, 32'h0000_00a5);
      bus(`UFW_OFS_RECEIVE_PORT, 1'b0, 32'h0);
      check("receive write", {31'h0, rd[31]}, 32'h1);
      wr_reg(`UFW_OFS_RECEIVE_CONFIG, 32'h0007_0001);
      rd_chk("receive_config rw", `UFW_OFS_RECEIVE_CONFIG, 32'h0007_0001);
      ufw_remote_inst.glitch(4);
      exp_q.delete();
      for (int i = 0; i < 10; i++)
      begin
         w = $urandom;
         if (i != 3 && exp_q.size() < 8) exp_q.push_back(w[7:0]);
         ufw_remote_inst.send_char(w[7:0], i == 3);
      end
      repeat (8) @(posedge hclk);
      rd_chk("receive mark", `UFW_OFS_IRQ_PENDING, exp_pending(0, 0, 8, 7));
      check("event out", {31'h0, event_irq}, 32'h1);
      for (int i = 0; i < 8; i++)
      begin
         bus(`UFW_OFS_RECEIVE_PORT, 1'b0, 32'h0);
         check("received char", 32'({rd[31], rd[7:0]}), 32'({1'b0, exp_q[i]}));
         if (i == 0)
            rd_chk("receive mark", `UFW_OFS_IRQ_PENDING, exp_pending(0, 0, 7, 7));
      end
      bus(`UFW_OFS_RECEIVE_PORT, 1'b0, 32'h0);
      check("receive empty", {31'h0, rd[31]}, 32'h1);
      $display("test receive done");
      final_report();
   end
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask : wr_reg
endmodule : ufw_uart_bench
